// ==== src/axis_flag_pkg.sv ====
/*
  Package for the axis flag, capture and compare block: register offsets,
  field positions, reset values, flag filter and capture types.
  Assumes a 32-bit APB register bus and four channels on the chip.
*/
package axis_flag_pkg;
  // ----------------------------------------------------------------------
  // Sizes.
  // ----------------------------------------------------------------------
  localparam int NCH = 4;  // Channels on the chip.
  localparam int NFLAG = 5;  // Fault, plus limit, minus limit, home, user.
  // ----------------------------------------------------------------------
  // Register byte offsets (one register bank for the channel).
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_OUTCTL = 12'h000;  // Output control register.
  localparam logic [11:0] OFS_STATUS = 12'h004;  // Input flag and state status.
  localparam logic [11:0] OFS_FILTCFG = 12'h008;  // Filter configuration.
  localparam logic [11:0] OFS_CAPCFG = 12'h00C;  // Capture configuration.
  localparam logic [11:0] OFS_CMPCFG = 12'h010;  // Compare configuration.
  localparam logic [11:0] OFS_CMPA = 12'h014;  // Match value A.
  localparam logic [11:0] OFS_CMPB = 12'h018;  // Match value B.
  localparam logic [11:0] OFS_CMPADD = 12'h01C;  // Match increment.
  localparam logic [11:0] OFS_FORCE = 12'h020;  // Match state force.
  localparam logic [11:0] OFS_CAPT = 12'h024;  // Captured position.
  localparam logic [11:0] OFS_CAPTF = 12'h028;  // Captured fine position.
  localparam logic [11:0] OFS_FINE = 12'h02C;  // Fine position.
  localparam logic [11:0] OFS_COUNT = 12'h030;  // Present count.
  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int DRIVE_ENABLE_BIT_INDEX = 8;  // In output control.
  localparam int DRIVE_FAULT_BIT_INDEX = 7;  // In status.
  localparam int FIRST_LIMIT_BIT_INDEX = 9;  // Plus limit; minus at +1.
  localparam int HOME_BIT = 16;  // Home flag in status.
  localparam int USER_BIT = 17;  // User flag in status.
  localparam int STATE_BIT = 18;  // Match state in status.
  localparam int LINE_BIT = 19;  // Line output level in status.
  localparam int TRIGGER_BIT_INDEX = 20;  // Capture trigger flag in status.
  localparam int FAULT_LEVEL_BIT = 0;  // Fault active level in output control.
  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_ENC_DIV = 8'h07;  // 25 MHz / 8 = 3.125 MHz.
  localparam logic [7:0] RST_FILT_DIV = 8'h3F;  // Secondary filter divider.
  localparam logic [3:0] RST_AND_MASK = 4'h1;  // Own channel state only.
  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FLAG_HOME = 2'b00,
    FLAG_POSITIVE_LIMIT_FLAG = 2'b01,
    FLAG_NEGATIVE_LIMIT_FLAG = 2'b10,
    FLAG_USER = 2'b11
  } flag_sel_t;
  // Capture trigger control: index use and edge, flag use and edge.
  typedef struct packed {
    logic index_use;
    logic index_rise;
    logic flag_use;
    logic flag_rise;
  } capture_trigger_control_t;
  // Raw inputs of one channel.
  typedef struct packed {
    logic fault;
    logic positive_limit_flag;
    logic negative_limit_flag;
    logic home;
    logic user;
  } flags_t;
endpackage

// ==== src/axis_flag_capture_compare.sv ====
/*
  Flag filtering, position capture and position compare for channel 0 of
  a four-channel axis interface, with APB registers. The other channels'
  flags, compare states and channel 0 count arrive as inputs.
  Assumes the encoder count with 12 fraction bits comes from an outside
  counter on CLK, and that flag pins are asynchronous.
*/
// Behaviour
// R1: Drive enable 1 enables, reset forces 0
// R2: Limit bits read 1 when in limit
// R3: Software compares fault bit with active level
// R4: Flags sampled, two-of-three vote per sample
// R5: Optional second filter on filter clock
// R6: Fixed bit positions for enable, fault, limits, trigger
// R7: Latch position at once on trigger
// R8: Control picks index and flag, each edge
// R9: Flag select: home, plus, minus, user
// R10: Trigger flag from any chip channel
// R11: Capture holds 24.8 and 20.12 forms
// R12: Compare each sample, toggle on cross
// R13: Match values 32 bits, 12 fraction
// R14: Timer fraction used in compare
// R15: Count readback 8 or 12 fraction bits
// R16: Optional compare against channel zero count
// R17: Line is AND of masked states
// R18: Optional line invert, level readable
// R19: Crossing A adds increment to B, and reverse
// R20: Force field value and self-clearing request
// R21: Forced state skips next increment
// R22: Writing A or B re-arms increment
// R23: Filtered flags drive capture and status
`timescale 1ns/10ps
module axis_flag_capture_compare
  import axis_flag_pkg::*;
(
  input wire logic CLK,  // 25 MHz clock.
  input wire logic SRST,  // Synchronous reset, active high.
  input wire logic PSEL,  // APB select.
  input wire logic PENABLE,  // APB access phase.
  input wire logic PWRITE,  // APB write.
  input wire logic [11:0] PADDR,  // APB byte address.
  input wire logic [31:0] PWDATA,  // APB write data.
  output logic [31:0] PRDATA,  // APB read data.
  output logic PREADY,  // APB ready.
  output logic PSLVERR,  // APB error on unmapped address.
  input wire axis_flag_pkg::flags_t FLAGS_IN,  // Own flag pins.
  input wire logic [NCH-1:0] OTHER_TRIG_IN,  // Filtered trigger flags of channels.
  input wire logic INDEX_IN,  // Encoder index pin.
  input wire logic [31:0] COUNT_IN,  // Own count, 12 fraction bits.
  input wire logic [31:0] COUNT0_IN,  // Channel zero count, 12 fraction bits.
  input wire logic [NCH-1:0] STATES_IN,  // Compare states of all channels.
  input wire logic WATCHDOG_TRIP,  // Watchdog trip, forces drive off.
  output logic DRIVE_ENABLE,  // Amplifier enable output.
  output logic TRIGGER_FLAG,  // Own filtered selected trigger flag.
  output logic MATCH_STATE,  // Own compare state.
  output logic POSITION_MATCH_LINE  // Compare output line.
);
  import axis_flag_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] outctl_q;  // Output control register.
  logic [7:0] encoder_sample_divider_q;  // Sample clock divider.
  logic [7:0] filter_clock_divider_q;  // Secondary filter divider.
  logic second_filter_enable_q;  // Secondary filter enable.
  capture_trigger_control_t capture_trigger_control_q;  // Capture control.
  flag_sel_t trigger_source_select_q;  // Flag type for capture.
  logic [1:0] trigger_flag_channel_q;  // Channel of the trigger flag.
  logic timer_function_select_q;  // Timer function, 0 for estimate.
  logic arctangent_enable_q;  // Analog encoder readback scale.
  logic use_first_channel_count_q;  // Compare against channel zero.
  logic [3:0] line_and_mask_q;  // Mask of states for the line.
  logic line_invert_q;  // Line polarity.
  logic [31:0] match_value_a_q;  // Match value A.
  logic [31:0] match_value_b_q;  // Match value B.
  logic [31:0] match_increment_q;  // Match increment, signed.
  logic [1:0] match_state_force_q;  // Force field.
  logic match_state_q;  // Internal compare state.
  logic inhibit_q;  // Skip next auto increment.
  logic [31:0] captured_position_q;  // Capture, 24.8.
  logic [31:0] captured_fine_position_q;  // Capture, 20.12.
  logic [31:0] fine_position_q;  // Latest position, 20.12.
  logic [31:0] prev_pos_q;  // Position at previous sample.
  logic [7:0] enc_cnt_q;  // Sample clock counter.
  logic [7:0] filt_cnt_q;  // Filter clock counter.
  logic [NFLAG-1:0] sync1_q, sync2_q;  // Pin synchronisers.
  logic [NFLAG-1:0] smp1_q, smp2_q, smp3_q;  // Vote history.
  logic [NFLAG-1:0] vote_q;  // Voted flags.
  logic [NFLAG-1:0] f2a_q, f2b_q, f2c_q;  // Secondary filter history.
  logic [NFLAG-1:0] filt_q;  // Secondary filter output.
  logic [NFLAG-1:0] flags_f;  // Flags seen by logic.
  logic idx1_q, idx2_q, idx3_q;  // Index synchroniser and previous.
  logic trig_prev_q;  // Previous trigger flag level.
  logic [31:0] prdata_d;  // Read mux.
  logic addr_ok;  // Address decodes.
  logic wr;  // Write strobe.
  logic enc_tick, filt_tick;  // Divided clock enables.
  logic [31:0] pos;  // Compared position.
  logic cross_a, cross_b;  // Crossings this sample.
  logic trig_sel, flag_edge, idx_edge, capture;  // Capture terms.
  logic line_and;  // Combined states.

  assign wr = PSEL && PENABLE && PWRITE && addr_ok;
  assign enc_tick = (enc_cnt_q == encoder_sample_divider_q);
  assign filt_tick = (filt_cnt_q == filter_clock_divider_q);

  // ----------------------------------------------------------------------
  // Sample and filter clock dividers
  // ----------------------------------------------------------------------
  // Counters give a one-cycle sample tick and a filter tick that stays high for one whole sample period.
  always_ff @(posedge CLK) begin
    if (SRST || enc_tick) begin
      enc_cnt_q <= 8'h00;
    end else begin
      enc_cnt_q <= enc_cnt_q + 8'h01;
    end
  end

  // The filter clock ticks only on sample ticks, so it is the slower one.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      filt_cnt_q <= 8'h00;
    end else if (enc_tick) begin
      filt_cnt_q <= filt_tick ? 8'h00 : filt_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Flag filtering
  // ----------------------------------------------------------------------
  // Two flip-flops bring the pins into the clock domain.
  always_ff @(posedge CLK) begin
    sync1_q <= FLAGS_IN;
    sync2_q <= sync1_q;
    idx1_q <= INDEX_IN;
    idx2_q <= idx1_q;
  end

  // Each flag is voted best two of three over three sample ticks.
  generate
    for (genvar i = 0; i < NFLAG; i++) begin : g_flag
      always_ff @(posedge CLK) begin
        if (SRST) begin
          smp1_q[i] <= 1'b0;
          smp2_q[i] <= 1'b0;
          smp3_q[i] <= 1'b0;
          vote_q[i] <= 1'b0;
          f2a_q[i] <= 1'b0;
          f2b_q[i] <= 1'b0;
          f2c_q[i] <= 1'b0;
          filt_q[i] <= 1'b0;
        end else begin
          if (enc_tick) begin  // R4
            smp1_q[i] <= sync2_q[i];
            smp2_q[i] <= smp1_q[i];
            smp3_q[i] <= smp2_q[i];
            vote_q[i] <= (smp1_q[i] & smp2_q[i]) | (smp2_q[i] & smp3_q[i]) |
                         (smp1_q[i] & smp3_q[i]);
          end
          if (enc_tick && filt_tick) begin  // R5
            f2a_q[i] <= vote_q[i];
            f2b_q[i] <= f2a_q[i];
            f2c_q[i] <= f2b_q[i];
            filt_q[i] <= (f2a_q[i] & f2b_q[i]) | (f2b_q[i] & f2c_q[i]) |
                         (f2a_q[i] & f2c_q[i]);
          end
        end
      end
    end
  endgenerate

  // The secondary filter sits in the path only when enabled.
  assign flags_f = second_filter_enable_q ? filt_q : vote_q;  // R5 R23

  // ----------------------------------------------------------------------
  // Capture trigger
  // ----------------------------------------------------------------------
  // The selected flag type of this channel is offered to every channel.
  always_comb begin
    case (trigger_source_select_q)  // R9
      FLAG_HOME: TRIGGER_FLAG = flags_f[1];
      FLAG_POSITIVE_LIMIT_FLAG: TRIGGER_FLAG = flags_f[3];
      FLAG_NEGATIVE_LIMIT_FLAG: TRIGGER_FLAG = flags_f[2];
      default: TRIGGER_FLAG = flags_f[0];
    endcase
  end

  // The trigger flag may come from any channel; index 0 is this channel.
  assign trig_sel = (trigger_flag_channel_q == 2'b00) ? TRIGGER_FLAG :
                    OTHER_TRIG_IN[trigger_flag_channel_q];  // R10
  assign flag_edge = capture_trigger_control_q.flag_rise ? (trig_sel && !trig_prev_q) :
                     (!trig_sel && trig_prev_q);  // R8 R23
  assign idx_edge = capture_trigger_control_q.index_rise ? (idx2_q && !idx3_q) :
                    (!idx2_q && idx3_q);  // R8
  // With both used, both must occur together; with one, that one alone.
  assign capture = (capture_trigger_control_q.index_use || capture_trigger_control_q.flag_use)
                   && (!capture_trigger_control_q.index_use || idx_edge)
                   && (!capture_trigger_control_q.flag_use || flag_edge);

  // Previous levels for edge detection; reset copies them, so no false edge.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      idx3_q <= idx2_q;
      trig_prev_q <= trig_sel;
    end else begin
      idx3_q <= idx2_q;
      trig_prev_q <= trig_sel;
    end
  end

  // The position is latched in the same cycle as the edge.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      captured_position_q <= 32'h0000_0000;
      captured_fine_position_q <= 32'h0000_0000;
    end else if (capture) begin  // R7
      captured_position_q <= {{4{pos[31]}}, pos[31:4]};  // R11
      captured_fine_position_q <= pos;  // R11
    end
  end

  // ----------------------------------------------------------------------
  // Position compare
  // ----------------------------------------------------------------------
  // With the timer estimate off the fraction below a count is dropped.
  assign pos = (use_first_channel_count_q ? COUNT0_IN : COUNT_IN) &  // R16
               (timer_function_select_q ? 32'hFFFF_F000 : 32'hFFFF_FFFF);  // R14
  // A value is crossed when it lies between last and present sample.
  assign cross_a = enc_tick &&
    ((($signed(prev_pos_q) < $signed(match_value_a_q)) &&
      ($signed(pos) >= $signed(match_value_a_q))) ||
     (($signed(prev_pos_q) > $signed(match_value_a_q)) &&
      ($signed(pos) <= $signed(match_value_a_q))));  // R12
  assign cross_b = enc_tick &&
    ((($signed(prev_pos_q) < $signed(match_value_b_q)) &&
      ($signed(pos) >= $signed(match_value_b_q))) ||
     (($signed(prev_pos_q) > $signed(match_value_b_q)) &&
      ($signed(pos) <= $signed(match_value_b_q))));  // R12

  // Sample position and fine position register.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prev_pos_q <= 32'h0000_0000;
      fine_position_q <= 32'h0000_0000;
    end else if (enc_tick) begin
      prev_pos_q <= pos;
      fine_position_q <= pos;  // R15
    end
  end

  // Compare state: force wins over a crossing toggle.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      match_state_q <= 1'b0;
    end else if (match_state_force_q[0]) begin
      match_state_q <= match_state_force_q[1];  // R20
    end else if (cross_a ^ cross_b) begin
      match_state_q <= !match_state_q;  // R12
    end
  end

  // Force field; the request bit clears itself once forced.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      match_state_force_q <= 2'b00;
    end else if (wr && PADDR == OFS_FORCE) begin
      match_state_force_q <= PWDATA[1:0];
    end else begin
      match_state_force_q[0] <= 1'b0;  // R20
    end
  end

  // Inhibit of the first increment after a force; a value write re-arms.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      inhibit_q <= 1'b0;
    end else if (wr && (PADDR == OFS_CMPA || PADDR == OFS_CMPB)) begin
      inhibit_q <= 1'b0;  // R22
    end else if (match_state_force_q[0]) begin
      inhibit_q <= 1'b1;  // R21
    end else if (cross_a || cross_b) begin
      inhibit_q <= 1'b0;  // R21
    end
  end

  // Match values: software writes, or increments after a crossing.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      match_value_a_q <= 32'h0000_0000;
      match_value_b_q <= 32'h0000_0000;
    end else begin
      if (wr && PADDR == OFS_CMPA) begin
        match_value_a_q <= PWDATA;  // R13
      end else if (cross_b && !inhibit_q && match_increment_q != 32'h0000_0000) begin
        match_value_a_q <= match_value_a_q + match_increment_q;  // R19
      end
      if (wr && PADDR == OFS_CMPB) begin
        match_value_b_q <= PWDATA;  // R13
      end else if (cross_a && !inhibit_q && match_increment_q != 32'h0000_0000) begin
        match_value_b_q <= match_value_b_q + match_increment_q;  // R19
      end
    end
  end

  // Output line: AND of masked states, optionally inverted, registered.
  assign line_and = &(STATES_IN | ~line_and_mask_q);  // R17
  always_ff @(posedge CLK) begin
    if (SRST) begin
      POSITION_MATCH_LINE <= 1'b0;
    end else begin
      POSITION_MATCH_LINE <= line_and ^ line_invert_q;  // R18
    end
  end
  assign MATCH_STATE = match_state_q;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Configuration writes; reset and watchdog clear the drive enable.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      outctl_q <= 32'h0000_0000;
      encoder_sample_divider_q <= RST_ENC_DIV;
      filter_clock_divider_q <= RST_FILT_DIV;
      second_filter_enable_q <= 1'b0;
      capture_trigger_control_q <= 4'h0;
      trigger_source_select_q <= FLAG_HOME;
      trigger_flag_channel_q <= 2'b00;
      timer_function_select_q <= 1'b0;
      arctangent_enable_q <= 1'b0;
      use_first_channel_count_q <= 1'b0;
      line_and_mask_q <= RST_AND_MASK;
      line_invert_q <= 1'b0;
      match_increment_q <= 32'h0000_0000;
    end else begin
      if (WATCHDOG_TRIP) begin
        outctl_q[DRIVE_ENABLE_BIT_INDEX] <= 1'b0;  // R1
      end else if (wr && PADDR == OFS_OUTCTL) begin
        outctl_q <= PWDATA;
      end
      if (wr && PADDR == OFS_FILTCFG) begin
        encoder_sample_divider_q <= PWDATA[7:0];
        filter_clock_divider_q <= PWDATA[15:8];
        second_filter_enable_q <= PWDATA[16];
      end
      if (wr && PADDR == OFS_CAPCFG) begin
        capture_trigger_control_q <= PWDATA[3:0];
        trigger_source_select_q <= flag_sel_t'(PWDATA[5:4]);
        trigger_flag_channel_q <= PWDATA[7:6];
        timer_function_select_q <= PWDATA[8];
      end
      if (wr && PADDR == OFS_CMPCFG) begin
        use_first_channel_count_q <= PWDATA[0];
        line_and_mask_q <= PWDATA[4:1];
        line_invert_q <= PWDATA[5];
        arctangent_enable_q <= PWDATA[6];
      end
      if (wr && PADDR == OFS_CMPADD) begin
        match_increment_q <= PWDATA;
      end
    end
  end
  assign DRIVE_ENABLE = outctl_q[DRIVE_ENABLE_BIT_INDEX];  // R1

  // Read decode; unmapped addresses answer with an error.
  always_comb begin
    prdata_d = 32'h0000_0000;
    addr_ok = 1'b1;
    if (PADDR == OFS_OUTCTL) begin
      prdata_d = outctl_q;
    end else if (PADDR == OFS_STATUS) begin
      prdata_d[DRIVE_FAULT_BIT_INDEX] = flags_f[4];  // R6 R3
      prdata_d[FIRST_LIMIT_BIT_INDEX] = flags_f[3];  // R2 R6
      prdata_d[FIRST_LIMIT_BIT_INDEX+1] = flags_f[2];  // R2
      prdata_d[HOME_BIT] = flags_f[1];
      prdata_d[USER_BIT] = flags_f[0];
      prdata_d[STATE_BIT] = match_state_q;  // R12
      prdata_d[LINE_BIT] = POSITION_MATCH_LINE;  // R18
      prdata_d[TRIGGER_BIT_INDEX] = trig_sel;  // R6
    end else if (PADDR == OFS_FILTCFG) begin
      prdata_d = {15'h0000, second_filter_enable_q, filter_clock_divider_q,
                  encoder_sample_divider_q};
    end else if (PADDR == OFS_CAPCFG) begin
      prdata_d = {23'h00_0000, timer_function_select_q, trigger_flag_channel_q,
                  trigger_source_select_q, capture_trigger_control_q};
    end else if (PADDR == OFS_CMPCFG) begin
      prdata_d = {25'h000_0000, arctangent_enable_q, line_invert_q, line_and_mask_q,
                  use_first_channel_count_q};
    end else if (PADDR == OFS_CMPA) begin
      prdata_d = match_value_a_q;
    end else if (PADDR == OFS_CMPB) begin
      prdata_d = match_value_b_q;
    end else if (PADDR == OFS_CMPADD) begin
      prdata_d = match_increment_q;
    end else if (PADDR == OFS_FORCE) begin
      prdata_d = {30'h0000_0000, match_state_force_q};  // R20
    end else if (PADDR == OFS_CAPT) begin
      prdata_d = captured_position_q;
    end else if (PADDR == OFS_CAPTF) begin
      prdata_d = captured_fine_position_q;
    end else if (PADDR == OFS_FINE) begin
      prdata_d = fine_position_q;
    end else if (PADDR == OFS_COUNT) begin
      prdata_d = arctangent_enable_q ? pos : {{4{pos[31]}}, pos[31:4]};  // R15
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Zero wait states: data registered during setup, ready in access.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= prdata_d;
    end
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
endmodule

// ==== test/axis_flag_checker.sv ====
/*
  Checker of the flag, capture and compare block, bound to its top module.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
module axis_flag_checker
  import axis_flag_pkg::*;
(
  input wire logic CLK,  // Clock.
  input wire logic SRST,  // Reset.
  input wire logic PSEL,  // Select.
  input wire logic PENABLE,  // Access phase.
  input wire logic PWRITE,  // Write.
  input wire logic [11:0] PADDR,  // Address.
  input wire logic [31:0] PWDATA,  // Write data.
  input wire logic PREADY,  // Ready.
  input wire logic PSLVERR,  // Error.
  input wire logic WATCHDOG_TRIP,  // Trip.
  input wire logic DRIVE_ENABLE,  // Drive enable.
  input wire logic MATCH_STATE  // Compare state.
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // Addresses past the last register, or not word aligned, are unmapped.
  wire logic bad = PADDR > OFS_COUNT || PADDR[1:0] != 2'h0;
  // A write that completes at this edge.
  sequence wr_at(a);
    PSEL && PENABLE && PWRITE && PADDR == a;
  endsequence
  AST_READY: assert property (PREADY) else $error("ready low");
  AST_ERR_ACC: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error idle");
  AST_ERR_MAP: assert property (PSEL && PENABLE && bad |-> PSLVERR) else $error("no error");
  AST_OK_MAP: assert property (PSEL && PENABLE && !bad |-> !PSLVERR) else $error("false error");
  AST_TRIP: assert property (WATCHDOG_TRIP |=> !DRIVE_ENABLE) else $error("trip ignored");
  AST_RST: assert property (disable iff (1'b0) SRST |=> !DRIVE_ENABLE && !MATCH_STATE)
    else $error("reset ignored");
  AST_DRIVE: assert property (wr_at(OFS_OUTCTL) ##0 !WATCHDOG_TRIP
    |=> DRIVE_ENABLE == $past(PWDATA[DRIVE_ENABLE_BIT_INDEX])) else $error("drive bit");
  AST_FORCE: assert property (wr_at(OFS_FORCE) ##0 PWDATA[0]
    |=> ##1 MATCH_STATE == $past(PWDATA[1], 2)) else $error("force failed");
endmodule
bind axis_flag_capture_compare axis_flag_checker axis_flag_checker_i (.CLK(CLK), .SRST(SRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .WATCHDOG_TRIP(WATCHDOG_TRIP),
  .DRIVE_ENABLE(DRIVE_ENABLE), .MATCH_STATE(MATCH_STATE));

// ==== test/axis_flag_partner.sv ====
/*
  Far side: switches, amplifier and encoder, commanded by the bench.
  Assumes the bench changes its commands just after CLK edges.
*/
`timescale 1ns/10ps
module axis_flag_partner
  import axis_flag_pkg::*;
(
  input wire logic clk,  // Clock.
  input wire axis_flag_pkg::flags_t want,  // Commanded pin levels.
  input wire logic load,  // Load the count.
  input wire logic [31:0] base,  // Count to load.
  input wire logic [31:0] step,  // Count change each clock.
  output axis_flag_pkg::flags_t flags,  // Pin levels.
  output logic index,  // Index pin.
  output logic [31:0] count  // Count, 12 fraction bits.
);
  // The amplifier shows faults at the programmed level; the encoder moves.
  always_ff @(posedge clk) begin
    flags <= want;
    count <= load ? base : count + step;
  end
  assign index = count[15];  // One index pulse every sixteen counts, high for eight.
endmodule

// ==== test/axis_flag_capture_compare_test.sv ====
/*
  Self-checking bench of the flag, capture and compare block.
  Assumes the far-side model and the bound checker beside the design.
*/
`timescale 1ns/10ps
module axis_flag_capture_compare_test;
  import axis_flag_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, trip, err, ld, f;
  logic drive, trig, state, line, index;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, count, base, step, rd, cnt, inc;
  flags_t flags, want;
  int mismatches, comparisons;
  axis_flag_capture_compare axis_flag_capture_compare_i (.CLK(clk), .SRST(srst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FLAGS_IN(flags),
    .OTHER_TRIG_IN({3'h0, trig}), .INDEX_IN(index), .COUNT_IN(count), .COUNT0_IN(count),
    .STATES_IN({3'h0, state}), .WATCHDOG_TRIP(trip), .DRIVE_ENABLE(drive),
    .TRIGGER_FLAG(trig), .MATCH_STATE(state), .POSITION_MATCH_LINE(line));
  axis_flag_partner axis_flag_partner_i (.clk(clk), .want(want), .load(ld), .base(base),
    .step(step), .flags(flags), .index(index), .count(count));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  // The coarse capture keeps 8 fraction bits.
  function automatic logic [31:0] coarse(input logic [31:0] c);
    return {{4{c[31]}}, c[31:4]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, then access until ready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compare run: the count moves 0x6400 past the starting point.
  task move;
    step <= 32'h100;
    repeat (100) @(posedge clk);
    step <= 32'h0;
  endtask
  task end_of_test;
    $display("TB: comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {srst, ld} = 2'h3;
    {psel, penable, pwrite, trip, paddr, pwdata, want, step} = '0;
    void'($urandom(32'hC3D6));
    base = $urandom & 32'h000F_FFF0;
    inc = ($urandom & 32'h0000_FFF0) + 32'h10;
    f = $urandom & 1;
    repeat (2) @(posedge clk);
    {srst, ld} <= 2'h0;
    chk({31'h0, drive}, 32'h0);
    apb(1'b1, OFS_OUTCTL, 32'h0000_0100);
    @(posedge clk);
    chk({31'h0, drive}, 32'h1);
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    @(posedge clk);
    chk({31'h0, drive}, 32'h0);
    $display("TB: drive test done");
    want <= '{fault: f, positive_limit_flag: 1'b1, negative_limit_flag: 1'b1, home: 1'b0, user: 1'b0};
    @(posedge clk);
    want.negative_limit_flag <= 1'b0;
    repeat (80) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[FIRST_LIMIT_BIT_INDEX +: 2]}, 32'h1);
    chk({31'h0, rd[DRIVE_FAULT_BIT_INDEX]}, {31'h0, f});
    apb(1'b1, OFS_CAPCFG, 32'h0000_0003);
    want.home <= 1'b1;
    repeat (80) @(posedge clk);
    apb(1'b0, OFS_CAPTF, 32'h0);
    chk(rd, base);
    apb(1'b0, OFS_CAPT, 32'h0);
    chk(rd, coarse(base));
    $display("TB: flag and capture tests done");
    for (int v = 3; v >= 1; v -= 2) begin
      apb(1'b1, OFS_FORCE, 32'(v));
      repeat (2) @(posedge clk);
      chk({31'h0, state}, 32'(v >> 1));
      apb(1'b0, OFS_FORCE, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
    end
    apb(1'b1, OFS_CMPA, count + 32'h2000);
    apb(1'b1, OFS_CMPB, 32'h7000_0000);
    apb(1'b1, OFS_CMPADD, inc);
    apb(1'b1, OFS_FORCE, 32'h1);
    move();
    chk({31'h0, state}, 32'h1);
    apb(1'b0, OFS_CMPB, 32'h0);
    chk(rd, 32'h7000_0000);
    cnt = count;
    apb(1'b1, OFS_CMPA, cnt + 32'h2000);
    move();
    chk({31'h0, state}, 32'h0);
    apb(1'b0, OFS_CMPB, 32'h0);
    chk(rd, 32'h7000_0000 + inc);
    chk({31'h0, line}, 32'h0);
    apb(1'b1, OFS_CMPCFG, 32'h0000_0022);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, line}, 32'h1);
    chk({31'h0, rd[LINE_BIT]}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("TB: compare tests done");
    end_of_test();
  end
endmodule
